// file: hdl/updown_timer_capture_compare.sv
// One up/down timer channel with compare and capture slots on APB
`timescale 1ns/100ps
`include "updown_timer_params.svh"
module updown_timer_capture_compare
	import updown_timer_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire ext_pins_t   PINS,
	output irq_t             IRQ
);
	logic [7:0]  base_clock_select_q;
	logic [7:0]  unit_mode_q;
	logic [7:0]  timer_control_q;
	logic [7:0]  capcmp_control_q;
	logic [9:0]  edge_select_q;
	logic [7:0]  prescaler_mode_q;
	logic [7:0]  capture_source_select_a_q;
	logic [15:0] period_compare_q;
	logic [15:0] second_compare_q;
	logic [15:0] slot0_q;
	logic [15:0] slot1_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        ovf_q;
	logic        down_q;
	logic [9:0]  div_q;
	logic [4:0]  s1_q;
	logic [4:0]  s2_q;
	logic [4:0]  s3_q;
	logic [4:0]  lvl_q;
	logic [4:0]  lvlp_q;
	logic [4:0]  rise;
	logic [4:0]  fall;
	logic [4:0]  vedge;
	logic [4:0]  agree;
	logic [31:0] rd_data;
	logic        mapped;
	logic        setup;
	logic        wr;
	logic        ce;
	logic        step;
	logic        up;
	logic        tick;
	logic        m0;
	logic        m1;
	logic        ext_clr;
	logic        wrap;
	logic        cap0;
	logic        cap1;
	logic [3:0]  k;
	logic [9:0]  mask;
	logic [1:0]  clr_sel;
	op_mode_t    op;
	irq_t        irq_d;

	assign ce    = timer_control_q[`F_CE];
	assign setup = PSEL & ~PENABLE;
	assign wr    = PSEL & PENABLE & PWRITE & PREADY;
	assign m0    = (cnt_q == period_compare_q);
	assign m1    = (cnt_q == second_compare_q);
	assign clr_sel = timer_control_q[`F_CLR +: 2];

	// Mode decode; the forbidden kind/variant pair falls back to free timer
	always_comb
	begin
		case ({unit_mode_q[`F_VAR], unit_mode_q[`F_KIND]})
			2'b01:   op = OP_UDA;
			2'b11:   op = OP_UDB;
			default: op = OP_GP;
		endcase
	end

	// Pins pass three flops; a level counts once stages two and three agree
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			s1_q   <= 5'h00;
			s2_q   <= 5'h00;
			s3_q   <= 5'h00;
			lvl_q  <= 5'h00;
			lvlp_q <= 5'h00;
		end
		else
		begin
			s1_q   <= PINS;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= (agree & s3_q) | (~agree & lvl_q);
			lvlp_q <= lvl_q;
		end
	end
	assign agree = ~(s2_q ^ s3_q);
	assign rise  = lvl_q & ~lvlp_q;
	assign fall  = ~lvl_q & lvlp_q;

	// Two edge-select bits per input: bit 0 rising, bit 1 falling
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_edge
			assign vedge[gi] = (edge_select_q[2*gi] & rise[gi])
				| (edge_select_q[2*gi+1] & fall[gi]);
		end
	endgenerate

	// Free divider; base clock is sysclk/4 or /8, prescaler adds /1../64
	always_ff @(posedge CLK)
	begin
		if (RST)
			div_q <= 10'h000;
		else
			div_q <= div_q + 10'h001;
	end
	always_comb
	begin
		k = `DIV_BASE + {3'h0, base_clock_select_q[0]};
		if (prescaler_mode_q[2:0] > `PRESC_MAX)
			k = k + {1'b0, `PRESC_MAX};
		else
			k = k + {1'b0, prescaler_mode_q[2:0]};
		mask = ~(10'h3FF << k);
		tick = ((div_q & mask) == mask);
	end

	// Count step and direction; decode mode picks how the pins combine
	always_comb
	begin
		step = 1'b0;
		up   = 1'b1;
		if (op == OP_GP)
			step = tick;
		else
		begin
			case (prescaler_mode_q[1:0])
				2'b00:
				begin
					step = vedge[0];
					up   = ~lvl_q[1];
				end
				2'b01:
				begin
					step = vedge[0] ^ vedge[1]; // both at once hold
					up   = vedge[0];
				end
				2'b10:
				begin
					step = vedge[0];
					up   = lvl_q[1];
				end
				2'b11:
				begin
					// Quadrature x4: an edge on one pin alone counts, edges on both at once hold, edge select unused
					step = (rise[0] | fall[0]) ^ (rise[1] | fall[1]);
					up   = (rise[0] | fall[0]) ? (lvl_q[0] != lvl_q[1])
						: (lvl_q[0] == lvl_q[1]);
				end
				default:
				begin
					step = 1'b0;
					up   = 1'b1;
				end
			endcase
		end
		step = step & ce;
	end

	// Next counter value: external clear first, then the mode's step rule
	always_comb
	begin
		ext_clr = ce & vedge[2] & (op == OP_UDA) & ~clr_sel[0];
		wrap    = 1'b0;
		cnt_d   = cnt_q;
		if (ext_clr)
			cnt_d = 16'h0000;
		else if (step)
		begin
			case (op)
				OP_UDA:
				begin
					if (up)
						cnt_d = (m0 & (clr_sel == 2'b01 || clr_sel == 2'b10))
							? 16'h0000 : cnt_q + 16'h0001;
					else if (timer_control_q[`F_RLD] && cnt_q == 16'h0000)
						cnt_d = period_compare_q;
					else
						cnt_d = cnt_q - 16'h0001;
				end
				OP_UDB:
				begin
					if (up)
						cnt_d = m0 ? 16'h0000 : cnt_q + 16'h0001;
					else
						cnt_d = m1 ? 16'h0000 : cnt_q - 16'h0001;
				end
				default:
				begin
					wrap  = (cnt_q == 16'hFFFF) & ~timer_control_q[`F_IVAL];
					cnt_d = (timer_control_q[`F_IVAL] & m0)
						? 16'h0000 : cnt_q + 16'h0001;
				end
			endcase
		end
	end

	// Counter; software may load it only while stopped
	always_ff @(posedge CLK)
	begin
		if (RST)
			cnt_q <= `RST_REG16;
		else if (wr && PADDR == `A_COUNT && !ce)
			cnt_q <= PWDATA[15:0];
		else
			cnt_q <= cnt_d;
	end

	// Status flags; a wrap in the clearing cycle keeps the flag set
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ovf_q  <= 1'b0;
			down_q <= 1'b0;
		end
		else
		begin
			ovf_q <= wrap | (ovf_q & ~(wr && PADDR == `A_TCTL && !PWDATA[`F_CE]));
			if (step)
				down_q <= ~up;
		end
	end

	// Captures only while counting; a stopped channel drops triggers
	assign cap0 = ce & ~capcmp_control_q[0] & vedge[3];
	assign cap1 = ce & ~capcmp_control_q[1]
		& (capture_source_select_a_q[0] ? vedge[4] : vedge[3]);

	// Match and capture events, one clock each
	always_comb
	begin
		irq_d.period_match_irq = step & m0 & (op != OP_UDB | up);
		irq_d.second_match_irq = step & m1 & (op != OP_UDB | ~up);
		irq_d.slot_zero_irq = cap0
			| (step & capcmp_control_q[0] & cnt_q == slot0_q);
		irq_d.slot_one_irq = cap1
			| (step & capcmp_control_q[1] & cnt_q == slot1_q);
	end
	always_ff @(posedge CLK)
	begin
		if (RST)
			IRQ <= '0;
		else
			IRQ <= irq_d;
	end

	// Slots: capture latches the counter; writes land only in compare mode
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			slot0_q <= `RST_REG16;
			slot1_q <= `RST_REG16;
		end
		else
		begin
			if (cap0)
				slot0_q <= cnt_q;
			else if (wr && PADDR == `A_SLOT0 && capcmp_control_q[0])
				slot0_q <= PWDATA[15:0];
			if (cap1)
				slot1_q <= cnt_q;
			else if (wr && PADDR == `A_SLOT1 && capcmp_control_q[1])
				slot1_q <= PWDATA[15:0];
		end
	end

	// Control registers; status has no write path
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			base_clock_select_q       <= `RST_REG8;
			unit_mode_q               <= `RST_REG8;
			timer_control_q           <= `RST_REG8;
			capcmp_control_q          <= `RST_REG8;
			edge_select_q             <= `RST_EDGE;
			prescaler_mode_q          <= `RST_REG8;
			capture_source_select_a_q <= `RST_REG8;
			period_compare_q          <= `RST_REG16;
			second_compare_q          <= `RST_REG16;
		end
		else if (wr)
		begin
			case (PADDR)
				`A_BASECLK:  base_clock_select_q <= PWDATA[7:0];
				`A_UNITMODE: unit_mode_q <= PWDATA[7:0];
				`A_TCTL:     timer_control_q <= PWDATA[7:0];
				`A_CCCTL:    capcmp_control_q <= PWDATA[7:0];
				`A_EDGE:     edge_select_q <= PWDATA[9:0];
				`A_PRESC:    prescaler_mode_q <= PWDATA[7:0];
				`A_CAPSRC:   capture_source_select_a_q <= PWDATA[7:0];
				`A_CMP0:     period_compare_q <= PWDATA[15:0];
				`A_CMP1:     second_compare_q <= PWDATA[15:0];
				default:     ;
			endcase
		end
	end

	// Read mux and address decode
	always_comb
	begin
		mapped  = 1'b1;
		rd_data = 32'h0000_0000;
		case (PADDR)
			`A_BASECLK:  rd_data[7:0] = base_clock_select_q;
			`A_UNITMODE: rd_data[7:0] = unit_mode_q;
			`A_TCTL:     rd_data[7:0] = timer_control_q;
			`A_CCCTL:    rd_data[7:0] = capcmp_control_q;
			`A_EDGE:     rd_data[9:0] = edge_select_q;
			`A_PRESC:    rd_data[7:0] = prescaler_mode_q;
			`A_STATUS:   rd_data[2:0] = {ce, down_q, ovf_q};
			`A_CAPSRC:   rd_data[7:0] = capture_source_select_a_q;
			`A_CMP0:     rd_data[15:0] = period_compare_q;
			`A_CMP1:     rd_data[15:0] = second_compare_q;
			`A_SLOT0:    rd_data[15:0] = slot0_q;
			`A_SLOT1:    rd_data[15:0] = slot1_q;
			`A_COUNT:    rd_data[15:0] = cnt_q;
			default:     mapped = 1'b0;
		endcase
	end

	// No wait state: answer is prepared in setup, ready in the first access cycle
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= setup;
			PSLVERR <= setup & ~mapped;
			if (setup && !PWRITE)
				PRDATA <= rd_data;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_stop_hold;
		!ce && !(wr && PADDR == `A_COUNT) |=> $stable(cnt_q);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

	property p_no_capture;
		!ce |=> IRQ == '0;
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("event while stopped");

	property p_cap0;
		cap0 |=> slot0_q == $past(cnt_q) && IRQ.slot_zero_irq;
	endproperty
	a_cap0: assert property (p_cap0) else $error("slot zero capture wrong");

	property p_cap1;
		ce && !capcmp_control_q[1] && capture_source_select_a_q[0] && vedge[4]
			|=> slot1_q == $past(cnt_q) && IRQ.slot_one_irq;
	endproperty
	a_cap1: assert property (p_cap1) else $error("slot one capture wrong");

	property p_cm0;
		step && m0 && (op != OP_UDB || up) |=> IRQ.period_match_irq;
	endproperty
	a_cm0: assert property (p_cm0) else $error("period match missed");

	property p_cm0b;
		op == OP_UDB && step && m0 && !up |=> !IRQ.period_match_irq;
	endproperty
	a_cm0b: assert property (p_cm0b) else $error("period irq on down count");

	property p_cm1b;
		op == OP_UDB && step && m1 && up |=> !IRQ.second_match_irq;
	endproperty
	a_cm1b: assert property (p_cm1b) else $error("second irq on up count");

	property p_quad;
		ce && op != OP_GP && prescaler_mode_q[1:0] == 2'b11
			&& rise[0] && !rise[1] && !fall[1] |-> step;
	endproperty
	a_quad: assert property (p_quad) else $error("quadrature edge ignored");

	sequence s_trg_settle;
		s2_q[3] && s3_q[3] && !lvl_q[3];
	endsequence
	sequence s_trg_armed;
		ce && !capcmp_control_q[0] && edge_select_q[6];
	endsequence
	property p_edge;
		s_trg_settle ##1 s_trg_armed |=> IRQ.slot_zero_irq;
	endproperty
	a_edge: assert property (p_edge) else $error("rising trigger not seen");

	property p_slot_cmp;
		step && capcmp_control_q[0] && cnt_q == slot0_q |=> IRQ.slot_zero_irq;
	endproperty
	a_slot_cmp: assert property (p_slot_cmp) else $error("slot compare missed");

	property p_status;
		setup && !PWRITE && PADDR == `A_STATUS |=> PRDATA[2] == $past(ce);
	endproperty
	a_status: assert property (p_status) else $error("status run bit wrong");
endmodule

// file: hdl/updown_timer_params.svh
// Register map, field positions, reset values and counts of the up/down timer
// Function
// - Capture/compare control picks mode, fixed while counting; code accepts writes while counting too
// - Each input edge selectable rising, falling, both
// - Prescaler picks count clock or decode mode
// - Fourth decode mode ignores count/direction edge settings
// - Status is read-only, reports counter state
// - Period compare irq; variant B only counting up
// - Second compare irq; variant B only counting down
// - Stopped counter ignores capture triggers
// - Slot zero captures on trigger zero edge
// - Slot one captures on selected trigger edge
// - Count enable starts and stops counter
// - Kind bit up/down; variant bit A/B
`ifndef UPDOWN_TIMER_PARAMS_SVH
`define UPDOWN_TIMER_PARAMS_SVH
`define A_BASECLK 8'h00
`define A_UNITMODE 8'h04
`define A_TCTL 8'h08
`define A_CCCTL 8'h0C
`define A_EDGE 8'h10
`define A_PRESC 8'h14
`define A_STATUS 8'h18
`define A_CAPSRC 8'h1C
`define A_CMP0 8'h20
`define A_CMP1 8'h24
`define A_SLOT0 8'h28
`define A_SLOT1 8'h2C
`define A_COUNT 8'h30
`define F_CE 7
`define F_IVAL 0
`define F_CLR 1
`define F_RLD 3
`define F_KIND 0
`define F_VAR 1
`define RST_REG8 8'h00
`define RST_REG16 16'h0000
`define RST_EDGE 10'h000
`define DIV_BASE 4'h2
`define PRESC_MAX 3'h6
`endif

// file: hdl/updown_timer_pkg.sv
// Types shared by the up/down timer channel
package updown_timer_pkg;
	typedef struct packed {
		logic ext_trigger_one;
		logic ext_trigger_zero;
		logic ext_clear_in;
		logic direction_in;
		logic count_pulse_in;
	} ext_pins_t;
	typedef struct packed {
		logic slot_one_irq;
		logic slot_zero_irq;
		logic second_match_irq;
		logic period_match_irq;
	} irq_t;
	typedef enum logic [1:0] {
		OP_GP  = 2'b00,
		OP_UDA = 2'b01,
		OP_UDB = 2'b11
	} op_mode_t;
endpackage

// file: verification/ext_pin_model.sv
// Behavioural model of the encoder, trigger and clear pins of one channel
`timescale 1ns/100ps
module ext_pin_model
	import updown_timer_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       go,
	input  wire logic [4:0] sel,
	output logic            busy,
	output ext_pins_t       pins
);
	logic [3:0] cnt_q;

	// Each pulse holds high four cycles and low at least five, so the pin filter never misses a level
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pins  <= '0;
			cnt_q <= 4'h0;
		end
		else if (cnt_q != 4'h0)
		begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h5)
				pins <= '0;
		end
		else if (go)
		begin
			pins  <= ext_pins_t'(sel);
			cnt_q <= 4'h8;
		end
	end

	// Busy covers the low half too, keeping back-to-back pulses apart
	assign busy = (cnt_q != 4'h0);
endmodule

// file: verification/updown_timer_capture_compare_test.sv
// Self-checking bench: register map, capture, counting and match interrupts
`timescale 1ns/100ps
`include "updown_timer_params.svh"
module updown_timer_capture_compare_test
	import updown_timer_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	ext_pins_t   pins;
	irq_t        irq;
	logic        go = 1'b0;
	logic [4:0]  sel = 5'h00;
	logic        busy;
	logic [7:0]  seen_q [4];
	logic [31:0] rd;
	logic        err;
	logic [7:0]  seen_base;
	int          bad_count = 0;
	int          checked = 0;
	logic [7:0]  cfg_a [11] = '{`A_BASECLK, `A_UNITMODE, `A_CCCTL, `A_CCCTL, `A_EDGE, `A_PRESC,
		`A_CAPSRC, `A_CMP0, `A_CMP1, `A_COUNT, `A_TCTL};
	logic [31:0] cfg_d [11] = '{32'h00000001, 32'h00000001, 32'h00000003, 32'h00000000, 32'h00000141,
		32'h00000004, 32'h00000001, 32'h00001238, 32'h00000000, 32'h00001234, 32'h00000006};

	always #5 clk = ~clk;

	// Count interrupt pulses, since each stands for a single cycle only
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
			seen_q[i] <= rst ? 8'h00 : seen_q[i] + {7'h00, irq[i]};
	end

	updown_timer_capture_compare dut_u (
		.CLK     (clk),
		.RST     (rst),
		.PSEL    (psel),
		.PENABLE (penable),
		.PWRITE  (pwrite),
		.PADDR   (paddr),
		.PWDATA  (pwdata),
		.PRDATA  (prdata),
		.PREADY  (pready),
		.PSLVERR (pslverr),
		.PINS    (pins),
		.IRQ     (irq)
	);

	ext_pin_model pin_u (
		.CLK  (clk),
		.RST  (rst),
		.go   (go),
		.sel  (sel),
		.busy (busy),
		.pins (pins)
	);

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdck(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h00000000);
		check(what, rd, exp);
	endtask

	// One pin pulse; returns once the pin is low again and the sync delay has passed
	task automatic pulse(input logic [4:0] s);
		int n;
		n = 0;
		@(posedge clk);
		go  <= 1'b1;
		sel <= s;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b1 && n < 20);
		go <= 1'b0;
		while (busy !== 1'b0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		if (n >= 40)
		begin
			bad_count++;
			final_report();
		end
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Every mapped word starts at zero, the next word is unmapped
		for (int a = 0; a <= 'h30; a += 4)
			rdck(8'(a), 32'h00000000, "reset value");
		apb(1'b0, 8'h34, 32'h00000000);
		check("unmapped error", {31'h0, err}, 32'h00000001);
		wr(`A_STATUS, 32'h000000FF);
		rdck(`A_STATUS, 32'h00000000, "status after write");
		// Configure while stopped, base clock first, slots left in capture mode
		for (int i = 0; i < 11; i++)
		begin
			wr(cfg_a[i], cfg_d[i]);
			rdck(cfg_a[i], cfg_d[i], "config readback");
		end
		pulse(5'h08);
		check("stopped capture irq", {24'h0, seen_q[2]}, 32'h00000000);
		rdck(`A_SLOT0, 32'h00000000, "stopped slot zero");
		wr(`A_TCTL, 32'h00000086);
		rdck(`A_STATUS, 32'h00000004, "running flag");
		pulse(5'h08);
		check("slot zero irq", {24'h0, seen_q[2]}, 32'h00000001);
		check("slot one ignores trigger zero", {24'h0, seen_q[3]}, 32'h00000000);
		rdck(`A_SLOT0, 32'h00001234, "slot zero capture");
		// Three up steps with direction held low
		repeat (3) pulse(5'h01);
		rdck(`A_COUNT, 32'h00001237, "counter after steps");
		pulse(5'h10);
		check("slot one irq", {24'h0, seen_q[3]}, 32'h00000001);
		rdck(`A_SLOT1, 32'h00001237, "slot one capture");
		rdck(`A_SLOT0, 32'h00001234, "slot zero held");
		// Stepping through the period value raises exactly one period match
		repeat (2) pulse(5'h01);
		check("period match irq", {24'h0, seen_q[0]}, 32'h00000001);
		check("second match irq", {24'h0, seen_q[1]}, 32'h00000000);
		rdck(`A_COUNT, 32'h00001239, "counter past match");
		wr(`A_TCTL, 32'h00000006);
		rdck(`A_STATUS, 32'h00000000, "stopped flag");
		pulse(5'h01);
		rdck(`A_COUNT, 32'h00001239, "counter stopped");
		// Variant B, mode 2: slot zero turned to compare with a fresh value
		wr(`A_UNITMODE, 32'h00000003);
		wr(`A_PRESC, 32'h00000005);
		wr(`A_EDGE, 32'h00000145);
		wr(`A_CCCTL, 32'h00000001);
		wr(`A_SLOT0, 32'h00001239);
		wr(`A_CMP1, 32'h00001238);
		wr(`A_TCTL, 32'h00000086);
		repeat (2) pulse(5'h02);
		check("slot zero compare irq", {24'h0, seen_q[2]}, 32'h00000002);
		check("second match on down", {24'h0, seen_q[1]}, 32'h00000001);
		check("no period match on down", {24'h0, seen_q[0]}, 32'h00000001);
		rdck(`A_STATUS, 32'h00000006, "down flag");
		rdck(`A_COUNT, 32'h00000000, "cleared on down match");
		// Counting up through the shared match value clears on the period compare only
		wr(`A_TCTL, 32'h00000006);
		wr(`A_COUNT, 32'h00001238);
		wr(`A_TCTL, 32'h00000086);
		pulse(5'h01);
		check("period match on up", {24'h0, seen_q[0]}, 32'h00000002);
		check("no second match on up", {24'h0, seen_q[1]}, 32'h00000001);
		rdck(`A_COUNT, 32'h00000000, "cleared on up match");
		// Mode 4 counts both edges of the count pin even with its edge bits clear
		wr(`A_TCTL, 32'h00000006);
		wr(`A_PRESC, 32'h00000007);
		wr(`A_EDGE, 32'h00000140);
		wr(`A_SLOT0, 32'h00000001);
		wr(`A_TCTL, 32'h00000086);
		pulse(5'h01);
		check("quadrature steps", {24'h0, seen_q[2]}, 32'h00000003);
		rdck(`A_COUNT, 32'h00000000, "quadrature net count");
		// Free timer in interval mode: three period matches inside a bounded wait
		wr(`A_TCTL, 32'h00000006);
		wr(`A_TCTL, 32'h00000001);
		wr(`A_UNITMODE, 32'h00000000);
		wr(`A_PRESC, 32'h00000000);
		wr(`A_CMP0, 32'h00000002);
		wr(`A_COUNT, 32'h00000000);
		seen_base = seen_q[0];
		wr(`A_TCTL, 32'h00000081);
		for (int i = 0; i < 300 && seen_q[0] != seen_base + 8'h03; i++)
			@(posedge clk);
		check("interval matches", {24'h0, seen_q[0] - seen_base}, 32'h00000003);
		if (seen_q[0] - seen_base != 8'h03)
			final_report();
		wr(`A_TCTL, 32'h00000001);
		apb(1'b0, `A_COUNT, 32'h00000000);
		check("interval bound", {31'h0, rd[15:0] <= 16'h0002}, 32'h00000001);
		final_report();
	end
endmodule
